//--- design/ilc_top.sv
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps

module ilc_top #(
  parameter int unsigned VEC_COUNT = ilc_pkg::ILC_VEC_COUNT
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Peripheral requests, one per vector slot.
  input wire logic [VEC_COUNT-1:0] irqPending,
  // CPU core side.
  input wire logic cpuReady,
  input wire logic cpuReturn,
  input wire logic [2:0] cpuReturnLevel,
  output logic intTake,
  output logic [15:0] intVector,
  output logic [1:0] intLevel,
  output logic intBusy,
  output logic [15:0] pswOut
);

  import ilc_pkg::*;

  localparam int unsigned IDX_W = $clog2(VEC_COUNT);
  localparam logic [1:0] ACC_LAST = 2'(ILC_ACCEPT_CYCLES - 1);

  // Registers.
  logic [7:0] lvlFirst_reg;
  logic [7:0] lvlSecond_reg;
  logic [7:0] lvlThird_reg;
  logic [7:0] excLow_reg;
  logic [7:0] excHigh_reg;
  logic [15:0] psw_reg;
  logic wrPend_reg;
  logic [31:0] wrAddr_reg;
  logic [2:0] wrSize_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  logic [31:0] hrdata_reg;
  logic intTake_reg;
  logic [15:0] intVector_reg;
  logic [1:0] intLevel_reg;
  logic intBusy_reg;
  logic [IDX_W-1:0] lastIdx_reg;
  logic [1:0] accCount_reg;
  ilc_acc_state_t accState_reg;

  // Next values.
  logic [7:0] lvlFirst_next;
  logic [7:0] lvlSecond_next;
  logic [7:0] lvlThird_next;
  logic [7:0] excLow_next;
  logic [7:0] excHigh_next;
  logic [15:0] psw_next;
  logic [1:0] accCount_next;
  ilc_acc_state_t accState_next;

  // Bus decode.
  wire addrPhase = hsel && (htrans == ILC_HTRANS_NONSEQ) && hready;
  wire readPhase = addrPhase && !hwrite;
  wire wrFirst = wrPend_reg && (wrAddr_reg == ILC_ADDR_LVL_FIRST);
  wire wrSecond = wrPend_reg && (wrAddr_reg == ILC_ADDR_LVL_SECOND);
  wire wrThird = wrPend_reg && (wrAddr_reg == ILC_ADDR_LVL_THIRD);
  wire wrExcLow = wrPend_reg && (wrAddr_reg == ILC_ADDR_EXC_LOW);
  wire wrExcHigh = wrPend_reg && (wrAddr_reg == ILC_ADDR_EXC_HIGH);
  wire wrPsw = wrPend_reg && (wrAddr_reg == ILC_ADDR_PSW);

  // Status word fields.
  wire globalEnable = psw_reg[ILC_PSW_IE_BIT];
  wire [2:0] curLevel = psw_reg[ILC_PSW_LVL_MSB:ILC_PSW_LVL_LSB];
  wire writeUnlock = psw_reg[ILC_PSW_WS_BIT];

  // Slot order of the packed field vector fixes each slot's vector address.
  wire [2*VEC_COUNT-1:0] levelCfg = {lvlThird_reg, lvlSecond_reg, lvlFirst_reg};

  // Arbitration.
  logic pickFound;
  logic [IDX_W-1:0] pickIndex;
  logic [1:0] pickLevel;

  ilc_pick #(
    .VEC_COUNT(VEC_COUNT),
    .IDX_W(IDX_W)
  ) uPick (
    .levelCfg(levelCfg),
    .globalEnable(globalEnable),
    .curLevel(curLevel),
    .irqPending(irqPending),
    .found(pickFound),
    .index(pickIndex),
    .level(pickLevel)
  );

  // The return cycle itself never accepts, so a request cannot slip in
  // between the return and the next instruction.
  wire acceptNow = pickFound && cpuReady && !cpuReturn && (accState_reg == ACC_IDLE);
  wire [15:0] pickVector = 16'(ILC_VEC_BASE + 16'({pickIndex, 2'b00}));

  // Level registers follow plain bus writes.
  assign lvlFirst_next = wrFirst ? hwdata[7:0] : lvlFirst_reg;
  assign lvlSecond_next = wrSecond ? hwdata[7:0] : lvlSecond_reg;
  assign lvlThird_next = wrThird ? hwdata[7:0] : lvlThird_reg;

  // Writes while locked are dropped silently but still answer OKAY.
  assign excLow_next = (wrExcLow && writeUnlock) ? hwdata[7:0] : excLow_reg;
  assign excHigh_next = (wrExcHigh && writeUnlock) ? hwdata[7:0] : excHigh_reg;

  // Acceptance beats a return, which beats a software write of the level field.
  wire [15:0] pswBase = wrPsw ? hwdata[15:0] : psw_reg;
  wire [2:0] lvlField = acceptNow ? {1'b0, pickLevel} :
                        cpuReturn ? cpuReturnLevel :
                        pswBase[ILC_PSW_LVL_MSB:ILC_PSW_LVL_LSB];
  assign psw_next = {pswBase[15:ILC_PSW_WS_BIT], lvlField, pswBase[ILC_PSW_IE_BIT:0]};

  // Branch sequence occupies the core for a fixed number of cycles.
  always_comb begin
    accState_next = accState_reg;
    accCount_next = accCount_reg;
    case (accState_reg)
      ACC_IDLE: begin
        if (acceptNow) begin
          accState_next = ACC_BRANCH;
          accCount_next = 2'b00;
        end
      end
      ACC_BRANCH: begin
        if (accCount_reg == ACC_LAST) begin
          accState_next = ACC_IDLE;
        end else begin
          accCount_next = 2'(accCount_reg + 2'b01);
        end
      end
      default: begin
        accState_next = ACC_IDLE;
        accCount_next = 2'b00;
      end
    endcase
  end

  // Read mux uses next values so a read right after a write sees the new data.
  wire [31:0] accStat = {23'h00_0000, (accState_next == ACC_BRANCH), 2'(intLevel_reg),
                         2'b00, 4'(lastIdx_reg)};
  logic [31:0] rdData;
  always_comb begin
    case (haddr)
      ILC_ADDR_LVL_FIRST: rdData = {24'h00_0000, lvlFirst_next};
      ILC_ADDR_LVL_SECOND: rdData = {24'h00_0000, lvlSecond_next};
      ILC_ADDR_LVL_THIRD: rdData = {24'h00_0000, lvlThird_next};
      ILC_ADDR_EXC_LOW: rdData = {24'h00_0000, excLow_next};
      ILC_ADDR_EXC_HIGH: rdData = {24'h00_0000, excHigh_next};
      ILC_ADDR_PSW: rdData = {16'h0000, psw_next};
      ILC_ADDR_ACC_STAT: rdData = accStat;
      default: rdData = 32'h0000_0000;
    endcase
  end

  // Bus pipeline.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_reg <= 1'b0;
    end else begin
      wrPend_reg <= addrPhase && hwrite;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrAddr_reg <= 32'h0000_0000;
    end else begin
      wrAddr_reg <= addrPhase ? haddr : wrAddr_reg;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrSize_reg <= 3'h0;
    end else begin
      wrSize_reg <= addrPhase ? hsize : wrSize_reg;
    end
  end

  // Zero wait states: every register answers in one cycle, so the slave never stretches a transfer.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout_reg <= 1'b1;
    end else begin
      hreadyout_reg <= 1'b1;
    end
  end

  // Only OKAY is ever answered; locked or unmapped writes are dropped without an error.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hresp_reg <= ILC_HRESP_OKAY;
    end else begin
      hresp_reg <= ILC_HRESP_OKAY;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_reg <= 32'h0000_0000;
    end else begin
      hrdata_reg <= readPhase ? rdData : 32'h0000_0000;
    end
  end

  // Register file.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lvlFirst_reg <= ILC_RST_LVL_CFG;
    end else begin
      lvlFirst_reg <= lvlFirst_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lvlSecond_reg <= ILC_RST_LVL_CFG;
    end else begin
      lvlSecond_reg <= lvlSecond_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lvlThird_reg <= ILC_RST_LVL_CFG;
    end else begin
      lvlThird_reg <= lvlThird_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      excLow_reg <= ILC_RST_EXC;
    end else begin
      excLow_reg <= excLow_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      excHigh_reg <= ILC_RST_EXC;
    end else begin
      excHigh_reg <= excHigh_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      psw_reg <= ILC_RST_PSW;
    end else begin
      psw_reg <= psw_next;
    end
  end

  // Acceptance outputs.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      intTake_reg <= 1'b0;
    end else begin
      intTake_reg <= acceptNow;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      intVector_reg <= 16'h0000;
    end else begin
      intVector_reg <= acceptNow ? pickVector : intVector_reg;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      intLevel_reg <= 2'b00;
    end else begin
      intLevel_reg <= acceptNow ? pickLevel : intLevel_reg;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lastIdx_reg <= '0;
    end else begin
      lastIdx_reg <= acceptNow ? pickIndex : lastIdx_reg;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      accState_reg <= ACC_IDLE;
    end else begin
      accState_reg <= accState_next;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      accCount_reg <= 2'b00;
    end else begin
      accCount_reg <= accCount_next;
    end
  end

  // Busy is loaded from the next state, so it stands in exactly the cycles of the branch state.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      intBusy_reg <= 1'b0;
    end else begin
      intBusy_reg <= (accState_next == ACC_BRANCH);
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign hrdata = hrdata_reg;
  assign intTake = intTake_reg;
  assign intVector = intVector_reg;
  assign intLevel = intLevel_reg;
  assign intBusy = intBusy_reg;
  assign pswOut = psw_reg;

endmodule : ilc_top

//--- design/ilc_pkg.sv
package ilc_pkg;

  // Sizes of the level control.
  localparam int unsigned ILC_VEC_COUNT = 12;
  localparam int unsigned ILC_LVL_W = 2;
  localparam int unsigned ILC_CUR_W = 3;
  localparam int unsigned ILC_PSW_W = 16;
  localparam int unsigned ILC_CFG_W = 8;
  localparam int unsigned ILC_ACCEPT_CYCLES = 3;

  // Status word field positions.
  localparam int unsigned ILC_PSW_IE_BIT = 7;
  localparam int unsigned ILC_PSW_LVL_LSB = 8;
  localparam int unsigned ILC_PSW_LVL_MSB = 10;
  localparam int unsigned ILC_PSW_WS_BIT = 11;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] ILC_IDX_LVL_FIRST = 16'h7f02;
  localparam logic [15:0] ILC_IDX_LVL_SECOND = 16'h7f03;
  localparam logic [15:0] ILC_IDX_LVL_THIRD = 16'h7f04;
  localparam logic [15:0] ILC_IDX_EXC_LOW = 16'h7f08;
  localparam logic [15:0] ILC_IDX_EXC_HIGH = 16'h7f09;
  localparam logic [15:0] ILC_IDX_PSW = 16'h7f10;
  localparam logic [15:0] ILC_IDX_ACC_STAT = 16'h7f11;

  localparam logic [31:0] ILC_ADDR_LVL_FIRST = {14'h0000, ILC_IDX_LVL_FIRST, 2'b00};
  localparam logic [31:0] ILC_ADDR_LVL_SECOND = {14'h0000, ILC_IDX_LVL_SECOND, 2'b00};
  localparam logic [31:0] ILC_ADDR_LVL_THIRD = {14'h0000, ILC_IDX_LVL_THIRD, 2'b00};
  localparam logic [31:0] ILC_ADDR_EXC_LOW = {14'h0000, ILC_IDX_EXC_LOW, 2'b00};
  localparam logic [31:0] ILC_ADDR_EXC_HIGH = {14'h0000, ILC_IDX_EXC_HIGH, 2'b00};
  localparam logic [31:0] ILC_ADDR_PSW = {14'h0000, ILC_IDX_PSW, 2'b00};
  localparam logic [31:0] ILC_ADDR_ACC_STAT = {14'h0000, ILC_IDX_ACC_STAT, 2'b00};

  // Reset values.
  localparam logic [7:0] ILC_RST_LVL_CFG = 8'h00;
  localparam logic [7:0] ILC_RST_EXC = 8'h00;
  localparam logic [15:0] ILC_RST_PSW = 16'h0000;

  // Vector addressing.
  localparam logic [15:0] ILC_VEC_BASE = 16'h8000;

  // Bus encodings.
  localparam logic [1:0] ILC_HTRANS_NONSEQ = 2'h2;
  localparam logic ILC_HRESP_OKAY = 1'b0;

  typedef enum logic [0:0] {
    ACC_IDLE,
    ACC_BRANCH
  } ilc_acc_state_t;

endpackage : ilc_pkg

//--- design/ilc_pick.sv
`timescale 1ns/1ps

module ilc_pick #(
  parameter int unsigned VEC_COUNT = 12,
  parameter int unsigned IDX_W = 4
) (
  // Configuration and status word view.
  input wire logic [2*VEC_COUNT-1:0] levelCfg,
  input wire logic globalEnable,
  input wire logic [2:0] curLevel,
  // Requests from the peripherals.
  input wire logic [VEC_COUNT-1:0] irqPending,
  // Winner.
  output logic found,
  output logic [IDX_W-1:0] index,
  output logic [1:0] level
);

  logic [VEC_COUNT-1:0] eligible;

  genvar g;
  generate
    for (g = 0; g < VEC_COUNT; g++) begin : gVec
      // A zero field reads as level 0, which never beats any current level.
      assign eligible[g] = irqPending[g] && globalEnable &&
                           ({1'b0, levelCfg[2*g+1 -: 2]} > curLevel);
    end
  endgenerate

  // Walking downward with >= lets the smallest vector win among equal levels.
  always_comb begin
    found = 1'b0;
    index = '0;
    level = 2'b00;
    for (int i = VEC_COUNT - 1; i >= 0; i--) begin
      if (eligible[i] && (levelCfg[2*i+1 -: 2] >= level)) begin
        found = 1'b1;
        index = IDX_W'(i);
        level = levelCfg[2*i+1 -: 2];
      end
    end
  end

endmodule : ilc_pick

//--- dv/ilc_core_model.sv
`timescale 1ns/1ps

module ilc_core_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Bench control.
  input wire logic slow,
  input wire logic doRet,
  input wire logic [2:0] retLvl,
  // Block side.
  input wire logic intTake,
  output logic cpuReady,
  output logic cpuReturn,
  output logic [2:0] cpuReturnLevel
);
  logic [2:0] holdCnt;
  // A slow core is still stacking for a while and cannot take another request.
  assign cpuReady = (holdCnt == 3'h0);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      holdCnt <= 3'h0;
      cpuReturn <= 1'b0;
      cpuReturnLevel <= 3'h0;
    end else begin
      holdCnt <= (intTake && slow) ? 3'h7 : holdCnt - {2'b00, holdCnt != 3'h0};
      cpuReturn <= doRet;
      // Outside a return the level lines carry no meaning, so they toggle.
      cpuReturnLevel <= doRet ? retLvl : ~cpuReturnLevel;
    end
  end
endmodule : ilc_core_model

//--- dv/ilc_asserts.sv
`timescale 1ns/1ps

module ilc_asserts #(
  parameter int unsigned VEC_COUNT = 12
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Requests and core side.
  input wire logic [VEC_COUNT-1:0] irqPending,
  input wire logic cpuReturn,
  input wire logic [2:0] cpuReturnLevel,
  input wire logic intTake,
  input wire logic [15:0] intVector,
  input wire logic [1:0] intLevel,
  input wire logic intBusy,
  input wire logic [15:0] pswOut
);
  logic [VEC_COUNT-1:0] pendQ;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) pendQ <= '0;
    else pendQ <= irqPending;
  end
  chk_ie_block: assert property (!pswOut[7] |=> !intTake)
    else $error("take while enable clear");
  chk_level_above: assert property (intTake |-> intLevel > $past(pswOut[10:8]))
    else $error("taken level not above current");
  chk_level_load: assert property (intTake |-> pswOut[10:8] == {1'b0, intLevel})
    else $error("current level not loaded");
  chk_vector_map: assert property (intTake |-> intVector[15:6] == 10'h200 && intVector[1:0] == 2'h0
    && intVector[5:2] < VEC_COUNT) else $error("vector outside slot range");
  chk_pend_source: assert property (intTake |-> pendQ[intVector[5:2]])
    else $error("taken slot was not pending");
  chk_busy_span: assert property (intTake |-> intBusy [*3] ##1 !intBusy)
    else $error("busy span wrong");
  chk_busy_block: assert property ((intBusy || cpuReturn) |=> !intTake)
    else $error("take while busy or returning");
  chk_return_level: assert property (cpuReturn |=> pswOut[10:8] == $past(cpuReturnLevel))
    else $error("return level not restored");
  cov_top_level: cover property (intTake && intLevel == 2'h3);
  cov_last_slot: cover property (intTake && intVector[5:2] == 4'hb);
  cov_return: cover property (cpuReturn);
endmodule : ilc_asserts

//--- dv/ilc_top_tb.sv
`timescale 1ns/1ps

module ilc_top_tb;
  import ilc_pkg::*;
  typedef struct packed {logic [31:0] a; logic [31:0] d; logic [31:0] e;} ilc_row_t;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [11:0] irqPending = '0;
  logic slow = 1'b0;
  logic doRet = 1'b0;
  logic [2:0] retLvl = '0;
  logic hreadyout, hresp, intTake, intBusy, cpuReady, cpuReturn;
  logic [31:0] hrdata, r;
  logic [15:0] intVector, pswOut;
  logic [1:0] intLevel;
  logic [2:0] cpuReturnLevel;
  int n_errors = 0;
  int total_checks = 0;
  int takes = 0;
  int t0;
  ilc_row_t rows [5] = '{'{ILC_ADDR_LVL_FIRST, 32'h0000_00a5, 32'h0000_00a5},
    '{ILC_ADDR_LVL_SECOND, 32'hffff_ff3c, 32'h0000_003c}, '{ILC_ADDR_LVL_THIRD, 32'h0000_00ff, 32'h0000_00ff},
    '{ILC_ADDR_PSW, 32'h0001_0340, 32'h0000_0340}, '{32'h0001_fc00, 32'h0000_0055, 32'h0000_0000}};

  ilc_top uut (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irqPending(irqPending), .cpuReady(cpuReady),
    .cpuReturn(cpuReturn), .cpuReturnLevel(cpuReturnLevel), .intTake(intTake),
    .intVector(intVector), .intLevel(intLevel), .intBusy(intBusy), .pswOut(pswOut));
  ilc_core_model core (.mclk(mclk), .reset_n(reset_n), .slow(slow), .doRet(doRet), .retLvl(retLvl),
    .intTake(intTake), .cpuReady(cpuReady), .cpuReturn(cpuReturn), .cpuReturnLevel(cpuReturnLevel));

  always #4 mclk = ~mclk;
  always @(posedge mclk) if (intTake === 1'b1) takes++;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Called just after a rising edge; read data is taken at the data-phase edge.
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= ILC_HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic arm(input int s, input logic [1:0] lv, input logic [15:0] processor_status_word, input int expN);
    bus(ILC_ADDR_LVL_FIRST + 32'(4 * (s / 4)), 1'b1, 32'(lv) << (2 * (s % 4)));
    bus(ILC_ADDR_PSW, 1'b1, {16'h0000, processor_status_word});
    t0 = takes;
    irqPending <= 12'h001 << s;
    repeat (12) @(posedge mclk);
    irqPending <= 12'h000;
    chk("take count", 32'(expN), 32'(takes - t0));
  endtask : arm

  task automatic doReset();
    reset_n <= 1'b0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 3; i++) begin
      bus(ILC_ADDR_LVL_FIRST + 32'(4 * i), 1'b0, '0);
      chk("level reset", 32'h0000_0000, r);
    end
    bus(ILC_ADDR_PSW, 1'b0, '0);
    chk("psw reset", 32'h0000_0000, r);
    $display("reset test done");
  endtask : doReset

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  initial begin
    doReset();
    foreach (rows[i]) begin
      bus(rows[i].a, 1'b1, rows[i].d);
      bus(rows[i].a, 1'b0, '0);
      chk("readback", rows[i].e, r);
    end
    $display("register test done");
    for (int s = 0; s < 12; s++) begin
      arm(s, 2'(s % 3 + 1), 16'h0080, 1);
      chk("vector", 32'h0000_8000 + 32'(4 * s), {16'h0000, intVector});
      chk("level", 32'(s % 3 + 1), {30'h0, intLevel});
      chk("psw level", 32'(s % 3 + 1), {29'h0, pswOut[10:8]});
    end
    $display("slot test done");
    arm(0, 2'h0, 16'h0080, 0);
    arm(0, 2'h3, 16'h0000, 0);
    arm(0, 2'h3, 16'h0380, 0);
    arm(0, 2'h3, 16'h0280, 1);
    $display("gating test done");
    // A higher request raised during the branch must wait for the busy span to end.
    bus(ILC_ADDR_LVL_FIRST, 1'b1, 32'h0000_00c1);
    bus(ILC_ADDR_PSW, 1'b1, 32'h0000_0080);
    t0 = takes;
    irqPending <= 12'h001;
    repeat (2) @(posedge mclk);
    irqPending <= 12'h009;
    repeat (3) @(posedge mclk);
    chk("busy hold", 32'h0000_0001, 32'(takes - t0));
    repeat (2) @(posedge mclk);
    chk("nest count", 32'h0000_0002, 32'(takes - t0));
    chk("nest vector", 32'h0000_800c, {16'h0000, intVector});
    chk("nest level", 32'h0000_0003, {29'h0, pswOut[10:8]});
    irqPending <= 12'h000;
    $display("nesting test done");
    slow <= 1'b1;
    bus(ILC_ADDR_LVL_FIRST, 1'b1, 32'h0000_00c8);
    bus(ILC_ADDR_LVL_SECOND, 1'b1, 32'h0000_000c);
    bus(ILC_ADDR_PSW, 1'b1, 32'h0000_0080);
    t0 = takes;
    irqPending <= 12'h02a;
    repeat (12) @(posedge mclk);
    chk("prio vector", 32'h0000_800c, {16'h0000, intVector});
    chk("prio count", 32'h0000_0001, 32'(takes - t0));
    retLvl <= 3'h5;
    doRet <= 1'b1;
    @(posedge mclk);
    doRet <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("return level", 32'h0000_0005, {29'h0, pswOut[10:8]});
    irqPending <= 12'h000;
    $display("priority test done");
    for (int u = 0; u < 2; u++) begin
      bus(ILC_ADDR_PSW, 1'b1, 32'(u) << 11);
      bus(ILC_ADDR_EXC_LOW, 1'b1, 32'h0000_005a);
      bus(ILC_ADDR_EXC_LOW, 1'b0, '0);
      chk("exception write", u ? 32'h0000_005a : 32'h0000_0000, r);
    end
    $display("unlock test done");
    doReset();
    conclude();
  end

  // The whole sequence needs about 350 cycles; this span of 12,500 cycles leaves ample margin.
  initial begin
    #100_000;
    n_errors++;
    conclude();
  end
endmodule : ilc_top_tb

bind ilc_top ilc_asserts #(.VEC_COUNT(VEC_COUNT)) chk_i (.mclk(mclk), .reset_n(reset_n),
  .irqPending(irqPending), .cpuReturn(cpuReturn), .cpuReturnLevel(cpuReturnLevel), .intTake(intTake),
  .intVector(intVector), .intLevel(intLevel), .intBusy(intBusy), .pswOut(pswOut));
